// file: rtl/ebpm_consts.svh
// constants for the external bus and port mapping block
`ifndef EBPM_CONSTS_SVH
`define EBPM_CONSTS_SVH

// register indices, byte address is four times the index
`define EBPM_IDX_UP_DATA   6'h00
`define EBPM_IDX_LO_DATA   6'h01
`define EBPM_IDX_UP_DIR    6'h02
`define EBPM_IDX_LO_DIR    6'h03
`define EBPM_IDX_CP_DATA   6'h08
`define EBPM_IDX_CP_DIR    6'h09
`define EBPM_IDX_CP_ASG    6'h0A
`define EBPM_IDX_MAP_CTL   6'h13
`define EBPM_IDX_BUS_REGS  6'h10
`define EBPM_IDX_PORT_LAST 6'h03

// map control fields
`define EBPM_MAP_FLASH_EN  0
`define EBPM_MAP_FLASH_HI  1
`define EBPM_MAP_PE_EMUL   2

// control port assignment fields
`define EBPM_ASG_NO_BUSEN  7
`define EBPM_ASG_PIPE_OE   5
`define EBPM_ASG_NO_BUSCK  4
`define EBPM_ASG_STRB_EN   3
`define EBPM_ASG_RW_EN     2

// reset values
`define EBPM_RST_DIR       8'h00
`define EBPM_RST_DATA      8'h00
`define EBPM_RST_ASG_NX    8'h00
`define EBPM_RST_ASG_SPC   8'h2C
`define EBPM_RST_ASG_NSC   8'h90
`define EBPM_RST_MAP_EXP   8'h00
`define EBPM_RST_MAP_SC    8'h03
`define EBPM_CP_OUT_MASK   8'hFC

`endif

// file: rtl/ebpm_pkg.sv
// types for the external bus and port mapping block
package ebpm_pkg;

	typedef enum logic [2:0]
	{
		EBPM_NORM_SINGLE,
		EBPM_SPEC_SINGLE,
		EBPM_NORM_NARROW,
		EBPM_NORM_WIDE,
		EBPM_SPEC_NARROW,
		EBPM_SPEC_WIDE,
		EBPM_PERIPHERAL
	} ebpm_mode_type;

	typedef enum logic [1:0]
	{
		EBPM_IDLE,
		EBPM_ADDR,
		EBPM_DATA,
		EBPM_DATA2
	} ebpm_state_type;

	typedef struct packed
	{
		logic        low_byte_strobe;
		logic        a0;
		logic        read_write;
		logic [15:0] data;
	} ebpm_access_type;

endpackage : ebpm_pkg

// file: rtl/ebpm_bus_port.sv
// port A/B/E bus expansion, flash placement and access type decode
// Notes on behaviour
// - flash at lower or upper half by bit
// - map bit resets zero expanded, one single-chip
// - map bit ignored while flash disabled
// - flash enable resets zero expanded, one single-chip
// - flash enable adds or removes flash
// - ram, registers not sent external, eeprom, debug rom beat flash
// - strobe marks size of every cycle
// - byte access strobe and a0 by parity
// - even word drives strobe zero, a0 zero
// - strobe and a0 both high only ram
// - misaligned word swaps data halves
// - peripheral mode drops first sixteen registers
// - expanded modes send port A/B registers external
// - emulation bit sends port E registers external
// - port A address high with data high in wide, every data byte in narrow
// - port B address low, data in wide
// - direction bit chooses input or output
// - assignment register picks port E functions
// - alternate function overrides port E direction
`include "ebpm_consts.svh"

module ebpm_bus_port #(
	parameter int AVS_ADDR_W = 8
) (
	input  wire logic                    clk,
	input  wire logic                    rst,
	input  wire logic                    clk_en,
	input  wire ebpm_pkg::ebpm_mode_type op_mode,
	input  wire logic [AVS_ADDR_W-1:0]   avs_address,
	input  wire logic                    avs_read,
	input  wire logic                    avs_write,
	input  wire logic [31:0]             avs_writedata,
	input  wire logic [3:0]              avs_byteenable,
	output logic      [31:0]             avs_readdata,
	output logic                         avs_waitrequest,
	input  wire logic                    cpu_req,
	input  wire logic                    cpu_write,
	input  wire logic                    cpu_word,
	input  wire logic [15:0]             cpu_addr,
	input  wire logic [15:0]             cpu_wdata,
	output logic      [15:0]             cpu_rdata,
	output logic                         cpu_ack,
	output logic                         cpu_err,
	input  wire logic                    ram_hit,
	input  wire logic                    reg_hit,
	input  wire logic                    eeprom_hit,
	input  wire logic                    debug_rom_hit,
	output logic                         flash_sel,
	output logic                         ext_sel,
	output ebpm_pkg::ebpm_access_type    access,
	input  wire logic [1:0]              queue_state,
	input  wire logic [7:0]              upper_port_in,
	output logic      [7:0]              upper_port_out,
	output logic      [7:0]              upper_port_oe,
	input  wire logic [7:0]              lower_port_in,
	output logic      [7:0]              lower_port_out,
	output logic      [7:0]              lower_port_oe,
	input  wire logic [7:0]              control_port_in,
	output logic      [7:0]              control_port_out,
	output logic      [7:0]              control_port_oe
);

	// ------------------------------------------------------------
	// mode decode
	// ------------------------------------------------------------
	wire single   = (op_mode == ebpm_pkg::EBPM_NORM_SINGLE) ||
	                (op_mode == ebpm_pkg::EBPM_SPEC_SINGLE);
	wire periph   = (op_mode == ebpm_pkg::EBPM_PERIPHERAL);
	wire expanded = !single && !periph;
	wire narrow   = (op_mode == ebpm_pkg::EBPM_NORM_NARROW) ||
	                (op_mode == ebpm_pkg::EBPM_SPEC_NARROW);
	wire special  = (op_mode == ebpm_pkg::EBPM_SPEC_SINGLE) ||
	                (op_mode == ebpm_pkg::EBPM_SPEC_NARROW) ||
	                (op_mode == ebpm_pkg::EBPM_SPEC_WIDE);

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	logic [7:0] up_data_r;
	logic [7:0] lo_data_r;
	logic [7:0] up_dir_r;
	logic [7:0] lo_dir_r;
	logic [7:0] cp_data_r;
	logic [7:0] cp_dir_r;
	logic [7:0] cp_asg_r;
	logic [7:0] map_ctl_r;
	logic       init_done_r;
	logic       av_ack_r;
	logic [7:0] av_rdata_r;

	wire flash_array_enable     = map_ctl_r[`EBPM_MAP_FLASH_EN];
	wire flash_high_half_select = map_ctl_r[`EBPM_MAP_FLASH_HI];
	wire port_e_emulation       = map_ctl_r[`EBPM_MAP_PE_EMUL];

	// ------------------------------------------------------------
	// avalon decode
	// ------------------------------------------------------------
	wire [5:0] av_idx     = avs_address[7:2];
	wire       av_req     = avs_read || avs_write;
	wire       per_drop   = periph && (av_idx < `EBPM_IDX_BUS_REGS);
	wire       ab_hidden  = !single;
	wire       e_hidden   = periph || (expanded && port_e_emulation);
	wire       hit_up_dat = (av_idx == `EBPM_IDX_UP_DATA) && !ab_hidden && !per_drop;
	wire       hit_lo_dat = (av_idx == `EBPM_IDX_LO_DATA) && !ab_hidden && !per_drop;
	wire       hit_up_dir = (av_idx == `EBPM_IDX_UP_DIR) && !ab_hidden && !per_drop;
	wire       hit_lo_dir = (av_idx == `EBPM_IDX_LO_DIR) && !ab_hidden && !per_drop;
	wire       hit_cp_dat = (av_idx == `EBPM_IDX_CP_DATA) && !e_hidden && !per_drop;
	wire       hit_cp_dir = (av_idx == `EBPM_IDX_CP_DIR) && !e_hidden && !per_drop;
	wire       hit_cp_asg = (av_idx == `EBPM_IDX_CP_ASG) && !per_drop;
	wire       hit_map    = (av_idx == `EBPM_IDX_MAP_CTL);
	wire       av_wr_en   = avs_write && av_ack_r && avs_byteenable[0] && clk_en;
	wire [7:0] av_wbyte   = avs_writedata[7:0];

	// port reads show the pin for inputs and the latch for outputs
	wire [7:0] up_rd = (upper_port_in & ~up_dir_r) | (up_data_r & up_dir_r);
	wire [7:0] lo_rd = (lower_port_in & ~lo_dir_r) | (lo_data_r & lo_dir_r);
	wire [7:0] cp_rd = (control_port_in & ~cp_dir_r) | (cp_data_r & cp_dir_r);
	wire [7:0] av_sel =
		hit_up_dat ? up_rd :
		hit_lo_dat ? lo_rd :
		hit_up_dir ? up_dir_r :
		hit_lo_dir ? lo_dir_r :
		hit_cp_dat ? cp_rd :
		hit_cp_dir ? (cp_dir_r & `EBPM_CP_OUT_MASK) :
		hit_cp_asg ? cp_asg_r :
		hit_map    ? map_ctl_r :
		8'h00;

	assign avs_waitrequest = av_req && !av_ack_r;
	assign avs_readdata    = {24'h00_0000, av_rdata_r};

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			av_ack_r   <= 1'b0;
			av_rdata_r <= 8'h00;
		end
		else if (clk_en)
		begin
			av_ack_r   <= av_req && !av_ack_r && init_done_r;
			av_rdata_r <= av_sel;
		end
	end

	// mode dependent defaults are caught at the first enabled edge after reset
	wire [7:0] asg_dflt =
		(op_mode == ebpm_pkg::EBPM_NORM_NARROW) ? `EBPM_RST_ASG_NX :
		(op_mode == ebpm_pkg::EBPM_NORM_WIDE)   ? `EBPM_RST_ASG_NX :
		special                                 ? `EBPM_RST_ASG_SPC :
		`EBPM_RST_ASG_NSC;
	wire [7:0] map_dflt = single ? `EBPM_RST_MAP_SC : `EBPM_RST_MAP_EXP;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			init_done_r <= 1'b0;
			cp_asg_r    <= `EBPM_RST_ASG_NX;
			map_ctl_r   <= `EBPM_RST_MAP_EXP;
		end
		else if (clk_en)
		begin
			init_done_r <= 1'b1;
			if (!init_done_r)
			begin
				cp_asg_r  <= asg_dflt;
				map_ctl_r <= map_dflt;
			end
			else
			begin
				if (av_wr_en && hit_cp_asg)
					cp_asg_r <= av_wbyte;
				if (av_wr_en && hit_map)
					map_ctl_r <= av_wbyte & 8'h07;
			end
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			up_data_r <= `EBPM_RST_DATA;
			lo_data_r <= `EBPM_RST_DATA;
			up_dir_r  <= `EBPM_RST_DIR;
			lo_dir_r  <= `EBPM_RST_DIR;
			cp_data_r <= `EBPM_RST_DATA;
			cp_dir_r  <= `EBPM_RST_DIR;
		end
		else if (clk_en && av_wr_en)
		begin
			if (hit_up_dat) up_data_r <= av_wbyte;
			if (hit_lo_dat) lo_data_r <= av_wbyte;
			if (hit_up_dir) up_dir_r  <= av_wbyte;
			if (hit_lo_dir) lo_dir_r  <= av_wbyte;
			if (hit_cp_dat) cp_data_r <= av_wbyte;
			if (hit_cp_dir) cp_dir_r  <= av_wbyte & `EBPM_CP_OUT_MASK;
		end
	end

	// ------------------------------------------------------------
	// internal bus decode
	// ------------------------------------------------------------
	wire [8:0] reg_off   = cpu_addr[8:0];
	wire       off_hi0   = (reg_off[8:6] == 3'h0);
	wire       off_port  = off_hi0 && (reg_off[5:0] <= `EBPM_IDX_PORT_LAST);
	wire       off_cp    = off_hi0 && ((reg_off[5:0] == `EBPM_IDX_CP_DATA) ||
	                                   (reg_off[5:0] == `EBPM_IDX_CP_DIR));
	wire       off_bus   = off_hi0 && (reg_off[5:0] < `EBPM_IDX_BUS_REGS);
	wire       reg_to_ext = reg_hit && ((expanded && off_port) ||
	                        (expanded && port_e_emulation && off_cp) ||
	                        (periph && off_bus));
	wire       reg_eff   = reg_hit && !reg_to_ext;
	wire       higher    = debug_rom_hit || reg_eff || ram_hit || eeprom_hit;
	wire       half_ok   = (cpu_addr[15] == flash_high_half_select);
	assign flash_sel = cpu_req && flash_array_enable && half_ok
	                   && !higher;
	assign ext_sel   = cpu_req && expanded && !higher && !flash_sel;

	// ------------------------------------------------------------
	// access type, strobe and a0
	// ------------------------------------------------------------
	wire       misalign = cpu_word && cpu_addr[0];
	wire       acc_strb = cpu_word ? cpu_addr[0] : !cpu_addr[0];
	wire [15:0] acc_dat = misalign ? {cpu_wdata[7:0], cpu_wdata[15:8]} : cpu_wdata;
	ebpm_pkg::ebpm_access_type access_r;
	assign access = access_r;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			access_r <= '{1'b1, 1'b0, 1'b1, 16'h0000};
		else if (clk_en && cpu_req && (!misalign || ram_hit))
			access_r <= '{acc_strb, cpu_addr[0], !cpu_write, acc_dat};
	end

	// ------------------------------------------------------------
	// external cycle sequencer
	// ------------------------------------------------------------
	ebpm_pkg::ebpm_state_type state_r;
	logic [15:0] addr_r;
	logic [15:0] wdata_r;
	logic        wr_r;
	logic        word_r;
	logic [15:0] rdata_r;
	logic        ack_r;
	logic        err_r;

	wire idle   = (state_r == ebpm_pkg::EBPM_IDLE);
	wire start  = ext_sel && idle && !ack_r && !misalign;
	wire reject = ext_sel && idle && !ack_r && misalign && !ram_hit;
	wire dphase = (state_r == ebpm_pkg::EBPM_DATA) || (state_r == ebpm_pkg::EBPM_DATA2);
	wire last   = (state_r == ebpm_pkg::EBPM_DATA2) ||
	              ((state_r == ebpm_pkg::EBPM_DATA) && !(narrow && word_r));
	wire [15:0] rd_sample =
		!narrow                             ? {upper_port_in, lower_port_in} :
		(state_r == ebpm_pkg::EBPM_DATA2)   ? {rdata_r[15:8], upper_port_in} :
		word_r                              ? {upper_port_in, 8'h00} :
		{upper_port_in, upper_port_in};

	assign cpu_ack   = ack_r;
	assign cpu_err   = err_r;
	assign cpu_rdata = rdata_r;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			state_r <= ebpm_pkg::EBPM_IDLE;
		else if (clk_en)
		begin
			case (state_r)
				ebpm_pkg::EBPM_IDLE:  if (start) state_r <= ebpm_pkg::EBPM_ADDR;
				ebpm_pkg::EBPM_ADDR:  state_r <= ebpm_pkg::EBPM_DATA;
				ebpm_pkg::EBPM_DATA:  state_r <= last ? ebpm_pkg::EBPM_IDLE : ebpm_pkg::EBPM_DATA2;
				ebpm_pkg::EBPM_DATA2: state_r <= ebpm_pkg::EBPM_IDLE;
				default:              state_r <= ebpm_pkg::EBPM_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			addr_r  <= 16'h0000;
			wdata_r <= 16'h0000;
			wr_r    <= 1'b0;
			word_r  <= 1'b0;
			rdata_r <= 16'h0000;
			ack_r   <= 1'b0;
			err_r   <= 1'b0;
		end
		else if (clk_en)
		begin
			ack_r <= (dphase && last) || reject;
			err_r <= reject;
			if (start)
			begin
				addr_r  <= cpu_addr;
				wdata_r <= cpu_wdata;
				wr_r    <= cpu_write;
				word_r  <= cpu_word;
			end
			if (dphase && !wr_r)
				rdata_r <= rd_sample;
		end
	end

	// ------------------------------------------------------------
	// port A and B pins
	// ------------------------------------------------------------
	wire       drv_data  = dphase && wr_r;
	wire [7:0] nar_byte  = (state_r == ebpm_pkg::EBPM_DATA2) ? wdata_r[7:0] :
	                       (word_r || !addr_r[0]) ? wdata_r[15:8] : wdata_r[7:0];
	wire [7:0] up_bus    = !dphase ? addr_r[15:8] : narrow ? nar_byte : wdata_r[15:8];
	wire [7:0] lo_addr   = (state_r == ebpm_pkg::EBPM_DATA2) ? {addr_r[7:1], 1'b1} : addr_r[7:0];
	wire [7:0] lo_bus    = (dphase && !narrow) ? wdata_r[7:0] : lo_addr;
	wire       up_bus_oe = expanded && (!dphase || drv_data);
	wire       lo_bus_oe = expanded && (narrow || !dphase || drv_data);

	assign upper_port_out = single ? up_data_r : up_bus;
	assign upper_port_oe  = single ? up_dir_r : {8{up_bus_oe}};
	assign lower_port_out = single ? lo_data_r : lo_bus;
	assign lower_port_oe  = single ? lo_dir_r : {8{lo_bus_oe}};

	// ------------------------------------------------------------
	// port E pins
	// ------------------------------------------------------------
	wire       strb_ok = !single && (op_mode != ebpm_pkg::EBPM_NORM_NARROW);
	wire [7:0] cp_alt = {
		!cp_asg_r[`EBPM_ASG_NO_BUSEN] && !single,
		{2{cp_asg_r[`EBPM_ASG_PIPE_OE] && !single}},
		expanded || !cp_asg_r[`EBPM_ASG_NO_BUSCK],
		cp_asg_r[`EBPM_ASG_STRB_EN] && strb_ok,
		cp_asg_r[`EBPM_ASG_RW_EN] && !single,
		2'b00
	};
	wire [7:0] cp_alt_val = {!dphase, queue_state, dphase, access_r.low_byte_strobe,
	                         access_r.read_write, 2'b00};
	wire [7:0] cp_gp_oe   = cp_dir_r & `EBPM_CP_OUT_MASK;

	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++)
		begin : g_cp_pin
			assign control_port_out[gi] = cp_alt[gi] ? cp_alt_val[gi] : cp_data_r[gi];
			assign control_port_oe[gi]  = cp_alt[gi] ? 1'b1 : cp_gp_oe[gi];
		end
	endgenerate

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst || !clk_en);

	flash_half_a: assert property (flash_sel |-> cpu_addr[15] == map_ctl_r[1])
		else $error("flash selected in wrong half");
	flash_off_a: assert property (!map_ctl_r[0] |-> !flash_sel)
		else $error("flash selected while disabled");
	flash_prio_a: assert property (
		(ram_hit || eeprom_hit || debug_rom_hit) |-> !flash_sel)
		else $error("flash beat higher resource");
	map_init_a: assert property ($rose(init_done_r) |-> map_ctl_r[1:0] == {2{single}})
		else $error("flash reset default wrong");
	byte_even_a: assert property ((cpu_req && !cpu_word && !cpu_addr[0])
		|=> access.low_byte_strobe && !access.a0)
		else $error("even byte strobe wrong");
	word_even_a: assert property ((cpu_req && cpu_word && !cpu_addr[0] && cpu_write)
		|=> !access.low_byte_strobe && !access.a0 && !access.read_write)
		else $error("even word strobe wrong");
	misalign_ram_a: assert property ($rose(access.low_byte_strobe && access.a0)
		|-> $past(ram_hit))
		else $error("misaligned strobe outside ram");
	port_ext_a: assert property ((expanded && cpu_req && reg_hit && off_port
		&& !ram_hit && !eeprom_hit && !debug_rom_hit) |-> ext_sel)
		else $error("port register stayed internal");
	gp_dir_a: assert property (single |-> upper_port_oe == up_dir_r
		&& lower_port_oe == lo_dir_r)
		else $error("port direction not applied");
	addr_phase_a: assert property ((state_r == ebpm_pkg::EBPM_ADDR && expanded)
		|-> upper_port_out == addr_r[15:8] ##1 dphase)
		else $error("address phase wrong");
	bus_clock_out_override_a: assert property (expanded |-> control_port_oe[4])
		else $error("clock pin not overriding direction");

endmodule : ebpm_bus_port

// file: dv/ebpm_ext_mem.sv
// far-side memory and port replacement model on the multiplexed bus
module ebpm_ext_mem
(
	input  wire logic       clk,
	input  wire logic       bus_on,
	input  wire logic       narrow,
	input  wire logic [7:0] gp_in,
	input  wire logic [7:0] upper_out,
	input  wire logic [7:0] lower_out,
	input  wire logic [7:0] ctl_out,
	output logic      [7:0] upper_in,
	output logic      [7:0] lower_in
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [7:0]  mem [0:65535];
	logic [15:0] addr_r = 16'h0000;
	wire         rd  = ctl_out[2];
	wire         dph = bus_on & ctl_out[4];
	wire  [15:0] ea  = narrow ? {addr_r[15:8], lower_out} : addr_r;
	wire  [15:0] ev  = {ea[15:1], 1'b0};
	wire  [15:0] od  = {ea[15:1], 1'b1};

	// address latched while the bus clock is low, data taken while high
	always @(posedge clk)
	begin
		if (bus_on && !ctl_out[4])
			addr_r <= {upper_out, lower_out};
		else if (dph && !rd && narrow)
			mem[ea] <= upper_out;
		else if (dph && !rd)
		begin
			if (!ea[0])
				mem[ev] <= upper_out;
			if (!ctl_out[3])
				mem[od] <= lower_out;
		end
	end

	// released lines show the inverse of what the block last drove
	assign upper_in = !bus_on ? gp_in : (dph && rd) ? (narrow ? mem[ea] : mem[ev]) : ~upper_out;
	assign lower_in = !bus_on ? gp_in : (dph && rd && !narrow) ? mem[od] : ~lower_out;
endmodule : ebpm_ext_mem

// file: dv/tb_top.sv
// self-checking bench for the bus and port mapping block
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	logic                      clk = 1'b0;
	logic                      rst = 1'b1;
	ebpm_pkg::ebpm_mode_type   op_mode = ebpm_pkg::EBPM_NORM_SINGLE;
	logic [7:0]                avs_address = 8'h00;
	logic                      avs_read = 1'b0;
	logic                      avs_write = 1'b0;
	logic [31:0]               avs_writedata = 32'h0000_0000;
	logic [31:0]               avs_readdata;
	logic                      avs_waitrequest;
	logic                      cpu_req = 1'b0;
	logic                      cpu_write = 1'b0;
	logic                      cpu_word = 1'b0;
	logic [15:0]               cpu_addr = 16'h0000;
	logic [15:0]               cpu_wdata = 16'h0000;
	logic [15:0]               cpu_rdata;
	logic                      cpu_ack;
	logic                      cpu_err;
	logic [3:0]                hit = 4'h0;
	logic                      flash_sel;
	logic                      ext_sel;
	ebpm_pkg::ebpm_access_type access;
	logic [7:0]                upper_port_in, upper_port_out, upper_port_oe;
	logic [7:0]                lower_port_in, lower_port_out, lower_port_oe;
	logic [7:0]                control_port_out, control_port_oe;
	int                        n_errors = 0;
	int                        num_checks = 0;
	int                        cyc = 0;
	int                        lat;
	logic [15:0]               q;
	logic [7:0]                rd;
	logic                      er, esel;
	wire                       narrow = op_mode inside {ebpm_pkg::EBPM_NORM_NARROW,
		ebpm_pkg::EBPM_SPEC_NARROW};
	wire                       bus_on = narrow || op_mode inside {ebpm_pkg::EBPM_NORM_WIDE,
		ebpm_pkg::EBPM_SPEC_WIDE};

	always #12.5 clk = ~clk;

	ebpm_bus_port uut
	(
		.clk, .rst, .clk_en(1'b1), .op_mode, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_byteenable(4'h1), .avs_readdata, .avs_waitrequest,
		.cpu_req, .cpu_write, .cpu_word, .cpu_addr, .cpu_wdata, .cpu_rdata, .cpu_ack,
		.cpu_err, .ram_hit(hit[0]), .reg_hit(hit[1]), .eeprom_hit(hit[2]),
		.debug_rom_hit(hit[3]), .flash_sel, .ext_sel, .access, .queue_state(2'b10),
		.upper_port_in, .upper_port_out, .upper_port_oe, .lower_port_in, .lower_port_out,
		.lower_port_oe, .control_port_in(8'h00), .control_port_out, .control_port_oe
	);

	ebpm_ext_mem far
	(
		.clk, .bus_on, .narrow, .gp_in(8'h3C), .upper_out(upper_port_out),
		.lower_out(lower_port_out), .ctl_out(control_port_out),
		.upper_in(upper_port_in), .lower_in(lower_port_in)
	);

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : tally_and_finish

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		num_checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic boot(input ebpm_pkg::ebpm_mode_type m);
		@(posedge clk);
		op_mode <= m;
		rst <= 1'b1;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
	endtask : boot

	task automatic avs(input logic wr, input logic [5:0] idx, input logic [7:0] wd);
		@(posedge clk);
		avs_address <= {idx, 2'b00};
		avs_writedata <= {24'h00_0000, wd};
		avs_write <= wr;
		avs_read <= !wr;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		rd = avs_readdata[7:0];
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : avs

	task automatic wr(input logic [5:0] idx, input logic [7:0] wd);
		avs(1'b1, idx, wd);
	endtask : wr

	task automatic rdc(input string what, input logic [5:0] idx, input logic [7:0] exp);
		avs(1'b0, idx, 8'h00);
		chk(what, 16'(exp), 16'(rd));
	endtask : rdc

	task automatic cpu(input logic w, input logic wd, input logic [15:0] a, input logic [15:0] d);
		@(posedge clk);
		cpu_req <= 1'b1;
		cpu_write <= w;
		cpu_word <= wd;
		cpu_addr <= a;
		cpu_wdata <= d;
		lat = 0;
		do
		begin
			@(posedge clk);
			lat++;
		end
		while (cpu_ack !== 1'b1);
		q = cpu_rdata;
		er = cpu_err;
		cpu_req <= 1'b0;
	endtask : cpu

	// one-cycle request to look at the decode, then let any cycle finish
	task automatic dck(input logic [15:0] a, input logic [3:0] h, input logic f);
		@(posedge clk);
		cpu_addr <= a;
		hit <= h;
		cpu_req <= 1'b1;
		@(negedge clk);
		esel = ext_sel;
		chk("flash sel", 16'(f), 16'(flash_sel));
		@(posedge clk);
		cpu_req <= 1'b0;
		hit <= 4'h0;
		repeat (8) @(posedge clk);
	endtask : dck

	task automatic acc(input string what, input logic [2:0] exp);
		@(negedge clk);
		chk(what, 16'(exp), 16'({access.low_byte_strobe, access.a0, access.read_write}));
	endtask : acc

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_single();
		boot(ebpm_pkg::EBPM_NORM_SINGLE);
		rdc("map reset", 6'h13, 8'h03);
		rdc("dir reset", 6'h02, 8'h00);
		rdc("assign reset", 6'h0A, 8'h90);
		wr(6'h00, 8'h5A);
		wr(6'h02, 8'h0F);
		wr(6'h03, 8'hF0);
		wr(6'h09, 8'hFF);
		@(negedge clk);
		chk("upper oe", 16'h000F, 16'(upper_port_oe));
		chk("upper out", 16'h000A, 16'(upper_port_out[3:0]));
		chk("lower oe", 16'h00F0, 16'(lower_port_oe));
		chk("control oe", 16'h00FC, 16'(control_port_oe));
		rdc("upper dir", 6'h02, 8'h0F);
		rdc("upper pins", 6'h00, 8'h3A);
		rdc("lower pins", 6'h01, 8'h0C);
		dck(16'h8000, 4'h0, 1'b1);
		dck(16'h0000, 4'h0, 1'b0);
		wr(6'h13, 8'h01);
		dck(16'h0000, 4'h0, 1'b1);
		dck(16'h8000, 4'h0, 1'b0);
		for (int i = 0; i < 4; i++)
			dck(16'h0100, 4'(1 << i), 1'b0);
		wr(6'h13, 8'h02);
		dck(16'h8000, 4'h0, 1'b0);
		dck(16'h0000, 4'h0, 1'b0);
	endtask : t_single

	task automatic t_wide();
		boot(ebpm_pkg::EBPM_SPEC_WIDE);
		rdc("map exp reset", 6'h13, 8'h00);
		rdc("assign special", 6'h0A, 8'h2C);
		dck(16'h8000, 4'h0, 1'b0);
		chk("ext sel", 16'h0001, 16'(esel));
		wr(6'h02, 8'h55);
		rdc("dir hidden", 6'h02, 8'h00);
		dck(16'h0002, 4'h2, 1'b0);
		chk("port reg external", 16'h0001, 16'(esel));
		@(negedge clk);
		chk("control oe bus", 16'h00FC, 16'(control_port_oe));
		chk("queue pins", 16'h0002, 16'(control_port_out[6:5]));
		wr(6'h09, 8'h80);
		rdc("cp dir", 6'h09, 8'h80);
		wr(6'h13, 8'h04);
		rdc("cp dir emulated", 6'h09, 8'h00);
		cpu(1'b1, 1'b1, 16'h1000, 16'hA55A);
		chk("wide word cycles", 16'h0004, 16'(lat));
		acc("word write", 3'b000);
		chk("mem even", 16'h00A5, 16'(far.mem[16'h1000]));
		chk("mem odd", 16'h005A, 16'(far.mem[16'h1001]));
		cpu(1'b1, 1'b0, 16'h1003, 16'h0077);
		acc("odd byte write", 3'b010);
		chk("mem byte", 16'h0077, 16'(far.mem[16'h1003]));
		chk("mem kept", 16'h005A, 16'(far.mem[16'h1001]));
		cpu(1'b0, 1'b0, 16'h1000, 16'h0000);
		acc("even byte read", 3'b101);
		chk("byte read", 16'h00A5, 16'(q[15:8]));
		cpu(1'b0, 1'b1, 16'h1000, 16'h0000);
		acc("word read", 3'b001);
		chk("word data", 16'hA55A, q);
		cpu(1'b1, 1'b1, 16'h1001, 16'h0000);
		chk("misaligned refused", 16'h0001, 16'(er));
		cpu_wdata <= 16'h1234;
		dck(16'h1001, 4'h1, 1'b0);
		acc("ram misaligned", 3'b110);
		chk("swapped", 16'h3412, access.data);
	endtask : t_wide

	task automatic t_narrow();
		boot(ebpm_pkg::EBPM_NORM_NARROW);
		wr(6'h0A, 8'h04);
		cpu(1'b1, 1'b1, 16'h2000, 16'hBEEF);
		chk("narrow even", 16'h00BE, 16'(far.mem[16'h2000]));
		chk("narrow odd", 16'h00EF, 16'(far.mem[16'h2001]));
		chk("narrow extra cycle", 16'h0005, 16'(lat));
		cpu(1'b0, 1'b1, 16'h2000, 16'h0000);
		chk("narrow read", 16'hBEEF, q);
	endtask : t_narrow

	task automatic t_resets();
		boot(ebpm_pkg::EBPM_SPEC_SINGLE);
		rdc("map spec single", 6'h13, 8'h03);
		rdc("assign spec single", 6'h0A, 8'h2C);
		@(negedge clk);
		chk("clock pin spec single", 16'h0001, 16'(control_port_oe[4]));
		boot(ebpm_pkg::EBPM_NORM_WIDE);
		rdc("map norm wide", 6'h13, 8'h00);
		rdc("assign norm wide", 6'h0A, 8'h00);
		boot(ebpm_pkg::EBPM_SPEC_NARROW);
		rdc("assign spec narrow", 6'h0A, 8'h2C);
	endtask : t_resets

	task automatic t_periph();
		boot(ebpm_pkg::EBPM_PERIPHERAL);
		wr(6'h02, 8'hFF);
		rdc("periph dir", 6'h02, 8'h00);
		rdc("periph assign", 6'h0A, 8'h00);
		@(negedge clk);
		chk("periph oe", 16'h0000, 16'(upper_port_oe));
	endtask : t_periph

	// ----------------------------------------------------------------
	// run and watchdog
	// ----------------------------------------------------------------
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			n_errors++;
			tally_and_finish();
		end
	end

	initial
	begin
		t_single();
		t_wide();
		t_narrow();
		t_resets();
		t_periph();
		tally_and_finish();
	end
endmodule : tb_top
